// >>> verilog/ilr_router.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ilr_router (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [12:0] src_in,
  output logic      [3:0]  int_line,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0] route_map_ff;
  logic [12:0] enable_ff;
  logic [12:0] src_s1_ff;
  logic [12:0] src_s2_ff;
  logic [12:0] src_prev_ff;
  logic [12:0] pending_ff;
  logic [3:0]  int_line_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_mask_ff;
  logic        irq_ff;
  logic [31:0] rdata_ff;
  logic [3:0]  nxt_lines;
  logic [3:0]  line_rise;

  function automatic logic [1:0] route_of(input logic [31:0] map,
                                          input int unsigned src);
    route_of = map[ilr_pkg::ROUTE_LSB + 2 * src +: 2];
  endfunction

  function automatic logic reg_hit(input logic        strobe,
                                   input logic [11:0] a,
                                   input logic [11:0] ofs);
    reg_hit = strobe && (a == ofs);
  endfunction

  assign int_line = int_line_ff;
  assign irq      = irq_ff;
  assign rdata    = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      route_map_ff <= ilr_pkg::ROUTE_MAP_RST;
    end else if (reg_hit(wr, addr, ilr_pkg::ROUTE_MAP_OFS)) begin
      route_map_ff <= wdata & ilr_pkg::ROUTE_MAP_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_ff <= ilr_pkg::ENABLE_RST;
    end else if (reg_hit(wr, addr, ilr_pkg::ENABLE_OFS)) begin
      enable_ff <= wdata[12:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_ff <= ilr_pkg::IRQ_MASK_RST;
    end else if (reg_hit(wr, addr, ilr_pkg::IRQ_MASK_OFS)) begin
      irq_mask_ff <= wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source capture: pins pass two flops first

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_s1_ff   <= 13'h0000;
      src_s2_ff   <= 13'h0000;
      src_prev_ff <= 13'h0000;
    end else begin
      src_s1_ff   <= src_in;
      src_s2_ff   <= src_s1_ff;
      src_prev_ff <= src_s2_ff;
    end
  end

  // pending latches on an enabled rising source; writing one clears it,
  // but a new rise in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending_ff <= 13'h0000;
    end else begin
      pending_ff <= (pending_ff
                     & ~(reg_hit(wr, addr, ilr_pkg::PENDING_OFS) ?
                         wdata[12:0] : 13'h0000))
                    | (src_s2_ff & ~src_prev_ff & enable_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing

  always_comb begin
    nxt_lines = 4'h0;
    for (int unsigned s = 0; s < ilr_pkg::NUM_SRC; s++) begin
      if (enable_ff[s] && pending_ff[s] && src_s2_ff[s]) begin
        case (ilr_pkg::ilr_line_t'(route_of(route_map_ff, s)))
          ilr_pkg::LINE_A: nxt_lines[0] = 1'b1;
          ilr_pkg::LINE_B: nxt_lines[1] = 1'b1;
          ilr_pkg::LINE_C: nxt_lines[2] = 1'b1;
          ilr_pkg::LINE_D: nxt_lines[3] = 1'b1;
          default: nxt_lines[0] = 1'b1;
        endcase
      end
    end
  end
  // fields: levels 1..7 at 3:2..15:14 power fail 17:16
  // system fail 19:18 ack cycle 21:20
  // irq edge 23:22 bp error 25:24 host error 27:26

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_line_ff <= 4'h0;
    end else begin
      int_line_ff <= nxt_lines;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: line rises are sticky, read clears, set wins

  assign line_rise = nxt_lines & ~int_line_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_ff <= 4'h0;
    end else if (reg_hit(rd, addr, ilr_pkg::IRQ_STAT_OFS)) begin
      irq_stat_ff <= line_rise;
    end else begin
      irq_stat_ff <= irq_stat_ff | line_rise;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after rd only

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        ilr_pkg::ROUTE_MAP_OFS: rdata_ff <= route_map_ff;
        ilr_pkg::ENABLE_OFS:    rdata_ff <= {19'h00000, enable_ff};
        ilr_pkg::PENDING_OFS:   rdata_ff <= {19'h00000, pending_ff};
        ilr_pkg::IRQ_STAT_OFS:  rdata_ff <= {28'h0000000, irq_stat_ff};
        ilr_pkg::IRQ_MASK_OFS:  rdata_ff <= {28'h0000000, irq_mask_ff};
        ilr_pkg::LINE_STAT_OFS: rdata_ff <= {28'h0000000, int_line_ff};
        default:                rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_map_write;
    wr && addr == ilr_pkg::ROUTE_MAP_OFS;
  endsequence

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (rst)
      (route_map_ff[31:28] == 4'h0) && (route_map_ff[1:0] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved map bits set");

  property p_map_write;
    @(posedge ref_clk) disable iff (rst)
      s_map_write |=>
        route_map_ff == ($past(wdata) & ilr_pkg::ROUTE_MAP_WMASK);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("map write not stored");

  property p_map_readback;
    @(posedge ref_clk) disable iff (rst)
      (rd && addr == ilr_pkg::ROUTE_MAP_OFS) |=> rdata == $past(route_map_ff);
  endproperty
  a_map_readback: assert property (p_map_readback)
    else $error("map read mismatch");

  property p_line_a_host_err;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[12] && pending_ff[12] && src_s2_ff[12]
       && route_map_ff[27:26] == 2'h0) |=> int_line[0];
  endproperty
  a_line_a_host_err: assert property (p_line_a_host_err)
    else $error("host error not on line a");

  property p_line_d_bp_err;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[11] && pending_ff[11] && src_s2_ff[11]
       && route_map_ff[25:24] == 2'h3) |=> int_line[3];
  endproperty
  a_line_d_bp_err: assert property (p_line_d_bp_err)
    else $error("backplane error not on line d");

  property p_level7_c;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[6] && pending_ff[6] && src_s2_ff[6]
       && route_map_ff[15:14] == 2'h2) |=> int_line[2];
  endproperty
  a_level7_c: assert property (p_level7_c)
    else $error("level 7 not on line c");

  property p_level1_b;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[0] && pending_ff[0] && src_s2_ff[0]
       && route_map_ff[3:2] == 2'h1) |=> int_line[1];
  endproperty
  a_level1_b: assert property (p_level1_b)
    else $error("level 1 not on line b");

  property p_idle_low;
    @(posedge ref_clk) disable iff (rst)
      ((enable_ff & pending_ff & src_s2_ff) == 13'h0000) |=> int_line == 4'h0;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("line high with no source");

  property p_irq_mask;
    @(posedge ref_clk) disable iff (rst)
      (irq_stat_ff & irq_mask_ff) != 4'h0 |=> irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq not raised");

  property p_edge_line_b;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[10] && pending_ff[10] && src_s2_ff[10]
       && route_map_ff[23:22] == 2'h1) |=> int_line[1];
  endproperty
  a_edge_line_b: assert property (p_edge_line_b)
    else $error("irq edge source not on line b");

  property p_ack_line_c;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[9] && pending_ff[9] && src_s2_ff[9]
       && route_map_ff[21:20] == 2'h2) |=> int_line[2];
  endproperty
  a_ack_line_c: assert property (p_ack_line_c)
    else $error("ack cycle source not on line c");

  property p_sys_fail_line_d;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[8] && pending_ff[8] && src_s2_ff[8]
       && route_map_ff[19:18] == 2'h3) |=> int_line[3];
  endproperty
  a_sys_fail_line_d: assert property (p_sys_fail_line_d)
    else $error("system fail source not on line d");

  property p_power_fail_line_a;
    @(posedge ref_clk) disable iff (rst)
      (enable_ff[7] && pending_ff[7] && src_s2_ff[7]
       && route_map_ff[17:16] == 2'h0) |=> int_line[0];
  endproperty
  a_power_fail_line_a: assert property (p_power_fail_line_a)
    else $error("power fail source not on line a");

  // an enabled synced rise always latches, even beside a clear write
  sequence s_src_rise;
    (src_s2_ff & ~src_prev_ff & enable_ff) != 13'h0000;
  endsequence

  property p_pend_set;
    @(posedge ref_clk) disable iff (rst)
      s_src_rise |=>
        (pending_ff & $past(src_s2_ff & ~src_prev_ff & enable_ff))
        == $past(src_s2_ff & ~src_prev_ff & enable_ff);
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("enabled rise not latched");

  property p_pend_clear;
    @(posedge ref_clk) disable iff (rst)
      reg_hit(wr, addr, ilr_pkg::PENDING_OFS) |=>
        (pending_ff & $past(wdata[12:0] & ~(src_s2_ff & ~src_prev_ff)))
        == 13'h0000;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending not cleared by write");

  property p_no_pend_disabled;
    @(posedge ref_clk) disable iff (rst)
      (pending_ff & ~$past(enable_ff) & ~$past(pending_ff)) == 13'h0000;
  endproperty
  a_no_pend_disabled: assert property (p_no_pend_disabled)
    else $error("disabled source latched");

  property p_line_needs_src;
    @(posedge ref_clk) disable iff (rst)
      (int_line != 4'h0) |->
        $past(enable_ff & pending_ff & src_s2_ff) != 13'h0000;
  endproperty
  a_line_needs_src: assert property (p_line_needs_src)
    else $error("line high without a live source");

  property p_map_hold;
    @(posedge ref_clk) disable iff (rst)
      !reg_hit(wr, addr, ilr_pkg::ROUTE_MAP_OFS) |=> $stable(route_map_ff);
  endproperty
  a_map_hold: assert property (p_map_hold)
    else $error("map changed without a write");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (rst)
      !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

  property p_stat_read_clear;
    @(posedge ref_clk) disable iff (rst)
      (reg_hit(rd, addr, ilr_pkg::IRQ_STAT_OFS) && line_rise == 4'h0)
        |=> irq_stat_ff == 4'h0;
  endproperty
  a_stat_read_clear: assert property (p_stat_read_clear)
    else $error("status not cleared by read");

  // host error walk: synced rise, then held on line b one cycle later
  sequence s_host_rise;
    enable_ff[12] && src_s2_ff[12] && !src_prev_ff[12];
  endsequence
  sequence s_host_held_b;
    enable_ff[12] && src_s2_ff[12] && route_map_ff[27:26] == 2'h1;
  endsequence

  property p_host_walk_b;
    @(posedge ref_clk) disable iff (rst)
      s_host_rise ##1 s_host_held_b |=> int_line[1];
  endproperty
  a_host_walk_b: assert property (p_host_walk_b)
    else $error("host error rise not on line b");

endmodule
`default_nettype wire

// >>> pkg/ilr_pkg.sv
// What this block does
// - route code 0..3 selects interrupt line a, b, c, d
// - host bus error route held in map bits 27:26, read/write
// - backplane error route held in map bits 25:24, read/write
// - backplane irq edge route held in map bits 23:22, read/write
// - acknowledge cycle route held in map bits 21:20, read/write
// - system fail route held in map bits 19:18, read/write
// - power fail route held in map bits 17:16, read/write
// - levels 7 down to 1 use pairs 15:14 down to 3:2
// - map register at offset 0x450, zero after reset
package ilr_pkg;

  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned NUM_SRC       = 13;
  localparam int unsigned NUM_LINES     = 4;

  localparam logic [11:0] ROUTE_MAP_OFS = 12'h450;
  localparam logic [11:0] ENABLE_OFS    = 12'h460;
  localparam logic [11:0] PENDING_OFS   = 12'h464;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h468;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h46c;
  localparam logic [11:0] LINE_STAT_OFS = 12'h470;

  localparam logic [31:0] ROUTE_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] ROUTE_MAP_WMASK = 32'h0fff_fffc;
  localparam logic [12:0] ENABLE_RST    = 13'h0000;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

  // source index i sits in map bits 2*i+3 : 2*i+2
  localparam int unsigned ROUTE_LSB     = 2;
  localparam int unsigned SRC_LEVEL1    = 0;
  localparam int unsigned SRC_LEVEL7    = 6;
  localparam int unsigned SRC_POWER_FAIL = 7;
  localparam int unsigned SRC_SYS_FAIL  = 8;
  localparam int unsigned SRC_ACK_CYCLE = 9;
  localparam int unsigned SRC_IRQ_EDGE  = 10;
  localparam int unsigned SRC_BP_ERROR  = 11;
  localparam int unsigned SRC_HOST_ERROR = 12;

  typedef enum logic [1:0] {
    LINE_A,
    LINE_B,
    LINE_C,
    LINE_D
  } ilr_line_t;

endpackage

// >>> testbench/ilr_host_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// host side interrupt controller: records which lines were ever raised
module ilr_host_ctl (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] int_line,
  output logic      [3:0] seen_ff
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_ff <= 4'h0;
    end else begin
      seen_ff <= seen_ff | int_line;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk;
  logic        rst;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [12:0] src_in;
  logic [3:0]  int_line;
  logic        irq;
  logic [3:0]  hit;
  logic [31:0] v;
  int          miscompares;
  int          cmp_count;

  ilr_router i_ilr_router (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_in(src_in),
    .int_line(int_line), .irq(irq));
  ilr_host_ctl i_ilr_host_ctl (.ref_clk(ref_clk), .rst(rst),
    .int_line(int_line), .seen_ff(hit));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd_reg(12'h450, v);
    chk("map_reset", v, 32'h0);
    wr_reg(12'h7fc, 32'hffff_ffff);
    rd_reg(12'h7fc, v);
    chk("unmapped", v, 32'h0);
  endtask

  task t_fields;
    wr_reg(12'h450, 32'hffff_ffff);
    rd_reg(12'h450, v);
    chk("map_rw", v, 32'h0fff_fffc);
    wr_reg(12'h450, 32'h0);
    rd_reg(12'h450, v);
    chk("map_clr", v, 32'h0);
    wr_reg(12'h450, 32'h0aaa_aaa8);
    rd_reg(12'h450, v);
    chk("map_alt", v, 32'h0aaa_aaa8);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(12'h450, v);
    chk("map_rerst", v, 32'h0);
  endtask

  task t_route;
    for (int i = 0; i < 13; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr_reg(12'h450, 32'(c) << (2 * i + 2));
        src_in[i] <= 1'b1;
        tick(6);
        chk("line_on", 32'(int_line), 32'h1 << c);
        src_in[i] <= 1'b0;
        tick(4);
        chk("line_off", 32'(int_line), 32'h0);
        wr_reg(12'h464, 32'h0000_1fff);
      end
    end
  endtask

  task t_irq;
    wr_reg(12'h450, 32'h0);
    rd_reg(12'h468, v);
    chk("stat_all", v, 32'hf);
    wr_reg(12'h46c, 32'h0000_0001);
    tick(2);
    chk("irq_idle", 32'(irq), 32'h0);
    src_in[12] <= 1'b1;
    tick(8);
    chk("irq_on", 32'(irq), 32'h1);
    rd_reg(12'h470, v);
    chk("line_state", v, 32'h1);
    src_in[12] <= 1'b0;
    wr_reg(12'h464, 32'h0000_1fff);
    rd_reg(12'h468, v);
    chk("stat_a", v, 32'h1);
    tick(2);
    chk("irq_clr", 32'(irq), 32'h0);
    wr_reg(12'h460, 32'h0000_0fff);
    src_in[12] <= 1'b1;
    tick(6);
    chk("off_line", 32'(int_line), 32'h0);
    rd_reg(12'h464, v);
    chk("off_pend", v, 32'h0);
    src_in[12] <= 1'b0;
    wr_reg(12'h460, 32'h0000_1fff);
    wr_reg(12'h46c, 32'h0);
    src_in[12] <= 1'b1;
    tick(8);
    chk("irq_mask", 32'(irq), 32'h0);
    chk("masked_line", 32'(int_line), 32'h1);
    wr_reg(12'h464, 32'h0000_1fff);
    tick(2);
    chk("held_line", 32'(int_line), 32'h0);
    src_in[12] <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    addr = 12'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    src_in = 13'h0000;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_fields;
    wr_reg(12'h460, 32'h0000_1fff);
    t_route;
    t_irq;
    chk("lines_seen", 32'(hit), 32'hf);
    close_out;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
